// ==== core/ccsm_pkg.sv ====
// Purpose: shared constants and types of the charge cycle state machine
// Assumes: one clock (mclk, 100 MHz), AXI4-Lite register access
// Notes: every offset, reset value and count used by more than one file
package ccsm_pkg;

  // ************************************************************
  // timeout figures
  // ************************************************************
  localparam int unsigned TIMEOUT_LOG2 = 22; // fast limit is 2^22 osc periods
  localparam int unsigned TIMEOUT_OSC_PERIODS = 1 << TIMEOUT_LOG2;
  localparam int unsigned TRICKLE_DIVISOR = 8; // trickle limit is one eighth

  // ************************************************************
  // register map, byte addresses
  // ************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00; // software enable
  localparam logic [7:0] OFS_STATE = 8'h04; // state and indicators
  localparam logic [7:0] OFS_TIMER = 8'h08; // timeout timer count
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c; // sticky events, write one to clear
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10; // event enables
  localparam logic CTRL_ENABLE_RST = 1'b1; // software enable after reset
  localparam logic [3:0] IRQ_MASK_RST = 4'h0; // all events masked after reset

  // event bit positions in status and mask
  localparam int unsigned EV_FAULT = 0; // entered timeout fault
  localparam int unsigned EV_COMPLETE = 1; // entered charge complete
  localparam int unsigned EV_INHIBIT = 2; // entered inhibit
  localparam int unsigned EV_TEMP = 3; // temperature left the window
  localparam int unsigned EV_N = 4;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // pin input positions in the synchroniser vector
  localparam int unsigned PIN_SUPPLY = 0;
  localparam int unsigned PIN_ENABLE = 1;
  localparam int unsigned PIN_TIMEOUT_EN = 2;
  localparam int unsigned PIN_PRECOND = 3;
  localparam int unsigned PIN_EOC = 4;
  localparam int unsigned PIN_TEMP = 5;
  localparam int unsigned PIN_OSC = 6;
  localparam int unsigned PIN_N = 7;

  // ************************************************************
  // charge states, one-hot
  // ************************************************************
  typedef enum logic [7:0] {
    CCSM_OFF      = 8'h01,
    CCSM_RESET    = 8'h02,
    CCSM_DISABLED = 8'h04,
    CCSM_TRICKLE  = 8'h08,
    CCSM_FAST     = 8'h10,
    CCSM_COMPLETE = 8'h20,
    CCSM_INHIBIT  = 8'h40,
    CCSM_FAULT    = 8'h80
  } ccsm_state_t;

endpackage : ccsm_pkg

// ==== core/ccsm_timer.sv ====
// Purpose: timeout timer counting oscillator periods
// Assumes: advance is a one-cycle pulse per oscillator period
// Notes: saturates at the full limit so expiry stays asserted
`timescale 1ns/1ns
`default_nettype none
module ccsm_timer #(
  parameter int unsigned CNT_W = 23,
  parameter int unsigned LIMIT = 4194304,
  parameter int unsigned DIVISOR = 8
) (
  input wire logic mclk,
  input wire logic rstN,
  input wire logic clear,
  input wire logic advance,
  output logic [CNT_W-1:0] count,
  output logic fullExpired,
  output logic partExpired
);

  // ************************************************************
  // limits at counter width
  // ************************************************************
  localparam logic [CNT_W-1:0] FULL_LIM = CNT_W'(LIMIT);
  localparam logic [CNT_W-1:0] PART_LIM = CNT_W'(LIMIT / DIVISOR);

  logic [CNT_W-1:0] count_reg; // periods since last clear

  // counter; clear wins over advance so entry always starts at zero
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      count_reg <= '0;
    end else if (clear) begin
      count_reg <= '0;
    end else if (advance && (count_reg != FULL_LIM)) begin
      count_reg <= count_reg + CNT_W'(1);
    end
  end

  assign count = count_reg;
  assign fullExpired = (count_reg >= FULL_LIM);
  assign partExpired = (count_reg >= PART_LIM);

endmodule : ccsm_timer
`default_nettype wire

// ==== core/ccsm_top.sv ====
// Purpose: control state machine of a single-cell charger
// Assumes: analog sense inputs arrive as asynchronous logic levels
// Notes: registers over AXI4-Lite, one level interrupt
// Notes on behaviour
// (R1) start powered off, reset when supply rises
// (R2) enable low after reset: disabled, no current
// (R3) enable high after reset: trickle charge
// (R4) trickle entry clears the timeout timer
// (R5) precondition reached in time: go fast
// (R6) trickle eighth-limit elapsed: timeout fault
// (R7) fault left only by enable toggle, power
// (R8) fast entry clears the timeout timer
// (R9) end-of-charge in fast: charge complete
// (R10) complete keeps current; timeout moves inhibit
// (R11) inhibit: output off, end-of-charge still shown
// (R12) fast limit is 2^22 oscillator periods
// (R13) fast timeout before end-of-charge: fault
// (R14) timeout enable low ignores the timeout
// (R15) temperature out of window pauses, flags fault
// (R16) enable low: disabled; supply loss: off
// (R17) fault indicator high throughout fault state
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module ccsm_top
  import ccsm_pkg::*;
#(
  parameter int unsigned TIMEOUT_TICKS = TIMEOUT_OSC_PERIODS
) (
  input wire logic mclk,
  input wire logic rst_n,
  // charger pins
  input wire logic supplyAbovePor,
  input wire logic chargeEnable,
  input wire logic timeoutEnableInput,
  input wire logic battAbovePrecond,
  input wire logic endOfCharge,
  input wire logic tempInWindow,
  input wire logic oscClk,
  output logic chargeOn,
  output logic trickleMode,
  output logic statusEoc,
  output logic faultInd,
  output logic irq,
  // AXI4-Lite slave
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);

  // ************************************************************
  // reset release
  // ************************************************************
  localparam int unsigned CNT_W = $clog2(TIMEOUT_TICKS + 1);

  logic [1:0] rstPipe_reg; // release path of the reset
  logic rstSyncN; // released reset used everywhere else

  // assert at once, release after two edges
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_reg <= 2'h0;
    end else begin
      rstPipe_reg <= {rstPipe_reg[0], 1'b1};
    end
  end
  assign rstSyncN = rstPipe_reg[1];

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [PIN_N-1:0] pinRaw; // asynchronous pins
  logic [PIN_N-1:0] pinMeta_reg; // first stage, read only by second
  logic [PIN_N-1:0] pinSync_reg; // safe copies
  logic oscDly_reg; // previous oscillator level, for edge
  logic oscTick; // one pulse per oscillator period

  assign pinRaw = {oscClk, tempInWindow, endOfCharge, battAbovePrecond,
                   timeoutEnableInput, chargeEnable, supplyAbovePor};

  // one two-stage synchroniser per pin
  for (genvar i = 0; i < PIN_N; i++) begin : gSync
    always_ff @(posedge mclk or negedge rstSyncN) begin
      if (!rstSyncN) begin
        pinMeta_reg[i] <= 1'b0;
        pinSync_reg[i] <= 1'b0;
      end else begin
        pinMeta_reg[i] <= pinRaw[i];
        pinSync_reg[i] <= pinMeta_reg[i];
      end
    end
  end

  // rising edge of the synchronised oscillator
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      oscDly_reg <= 1'b0;
    end else begin
      oscDly_reg <= pinSync_reg[PIN_OSC];
    end
  end
  assign oscTick = pinSync_reg[PIN_OSC] & ~oscDly_reg;

  // ************************************************************
  // state machine
  // ************************************************************
  ccsm_state_t state_reg; // current charge state
  ccsm_state_t state_next; // next charge state
  logic ctrlEnable_reg; // software enable, and-ed with the pin
  logic supplyOk; // supply above power-on threshold
  logic enabled; // effective charge enable
  logic toEnabled; // timeout function active
  logic tempOk; // temperature inside window
  logic timerClear; // entry into trickle or fast
  logic timerRun; // timer counts in this cycle
  logic fullExpired; // fast limit reached
  logic partExpired; // trickle limit reached
  logic [CNT_W-1:0] timerCount; // current count
  logic chargingState; // states that deliver current

  assign supplyOk = pinSync_reg[PIN_SUPPLY];
  assign enabled = pinSync_reg[PIN_ENABLE] & ctrlEnable_reg;
  assign toEnabled = pinSync_reg[PIN_TIMEOUT_EN];
  assign tempOk = pinSync_reg[PIN_TEMP];
  assign chargingState = (state_reg == CCSM_TRICKLE) || (state_reg == CCSM_FAST) ||
                         (state_reg == CCSM_COMPLETE);

  // next-state decode; supply loss first, then enable, then phase
  always_comb begin
    state_next = state_reg;
    if (!supplyOk) begin
      state_next = CCSM_OFF; // R16
    end else begin
      unique case (state_reg)
        CCSM_OFF: begin
          state_next = CCSM_RESET; // R1
        end
        CCSM_RESET: begin
          state_next = enabled ? CCSM_TRICKLE : CCSM_DISABLED; // R2 R3
        end
        CCSM_DISABLED: begin
          if (enabled) begin
            state_next = CCSM_TRICKLE; // R3
          end
        end
        CCSM_TRICKLE: begin
          if (!enabled) begin
            state_next = CCSM_DISABLED; // R16
          end else if (!tempOk) begin
            state_next = CCSM_TRICKLE; // R15
          end else if (pinSync_reg[PIN_PRECOND]) begin
            state_next = CCSM_FAST; // R5
          end else if (partExpired && toEnabled) begin
            state_next = CCSM_FAULT; // R6 R14
          end
        end
        CCSM_FAST: begin
          if (!enabled) begin
            state_next = CCSM_DISABLED; // R16
          end else if (!tempOk) begin
            state_next = CCSM_FAST; // R15
          end else if (pinSync_reg[PIN_EOC]) begin
            state_next = CCSM_COMPLETE; // R9
          end else if (fullExpired && toEnabled) begin
            state_next = CCSM_FAULT; // R13 R14
          end
        end
        CCSM_COMPLETE: begin
          if (!enabled) begin
            state_next = CCSM_DISABLED; // R16
          end else if (tempOk && fullExpired && toEnabled) begin
            state_next = CCSM_INHIBIT; // R10 R14
          end
        end
        CCSM_INHIBIT: begin
          if (!enabled) begin
            state_next = CCSM_DISABLED; // R16
          end
        end
        CCSM_FAULT: begin
          // only an enable drop (toggle) or supply loss gets out
          if (!enabled) begin
            state_next = CCSM_DISABLED; // R7
          end
        end
        default: begin
          state_next = CCSM_OFF; // illegal code recovers via reset path
        end
      endcase
    end
  end

  // state register; power-off is the reset state
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state_reg <= CCSM_OFF; // R1
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // timeout timer
  // ************************************************************
  // clear on every trickle or fast entry, so the limit is measured from that entry
  assign timerClear = ((state_next == CCSM_TRICKLE) || (state_next == CCSM_FAST)) &&
                      (state_next != state_reg); // R4 R8
  // paused outside the window; keeps running in complete
  assign timerRun = oscTick & tempOk & chargingState; // R15

  ccsm_timer #(
    .CNT_W(CNT_W),
    .LIMIT(TIMEOUT_TICKS), // R12
    .DIVISOR(TRICKLE_DIVISOR)
  ) uTimer (
    .mclk(mclk),
    .rstN(rstSyncN),
    .clear(timerClear),
    .advance(timerRun),
    .count(timerCount),
    .fullExpired(fullExpired),
    .partExpired(partExpired)
  );

  // ************************************************************
  // indicators
  // ************************************************************
  logic chargeOn_reg; // pass element on
  logic trickle_reg; // reduced trickle current
  logic status_reg; // end-of-charge shown
  logic fault_reg; // fault shown

  // registered from the current state; one cycle behind it
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      chargeOn_reg <= 1'b0;
      trickle_reg <= 1'b0;
      status_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      chargeOn_reg <= chargingState & tempOk; // R2 R10 R11 R15
      trickle_reg <= (state_reg == CCSM_TRICKLE) & tempOk;
      status_reg <= (state_reg == CCSM_COMPLETE) || (state_reg == CCSM_INHIBIT); // R10 R11
      fault_reg <= (state_reg == CCSM_FAULT) || (chargingState & ~tempOk); // R17 R15
    end
  end
  assign chargeOn = chargeOn_reg;
  assign trickleMode = trickle_reg;
  assign statusEoc = status_reg;
  assign faultInd = fault_reg;

  // ************************************************************
  // events and interrupt
  // ************************************************************
  logic [EV_N-1:0] events; // one-cycle event pulses
  logic [EV_N-1:0] irqStat_reg; // sticky events
  logic [EV_N-1:0] irqStat_next;
  logic [EV_N-1:0] irqMask_reg; // event enables
  logic [EV_N-1:0] irqClear; // write-one-to-clear bits
  logic tempBadDly_reg; // previous temperature fault level
  logic tempBad; // temperature fault while charging
  logic doWrite; // write address and data both held

  assign tempBad = chargingState & ~tempOk;
  assign events[EV_FAULT] = (state_next == CCSM_FAULT) && (state_reg != CCSM_FAULT);
  assign events[EV_COMPLETE] = (state_next == CCSM_COMPLETE) && (state_reg != CCSM_COMPLETE);
  assign events[EV_INHIBIT] = (state_next == CCSM_INHIBIT) && (state_reg != CCSM_INHIBIT);
  assign events[EV_TEMP] = tempBad & ~tempBadDly_reg;

  // set wins over a clear landing in the same cycle
  always_comb begin
    irqStat_next = (irqStat_reg & ~irqClear) | events;
  end

  // sticky status and edge history
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      irqStat_reg <= '0;
      tempBadDly_reg <= 1'b0;
    end else begin
      irqStat_reg <= irqStat_next;
      tempBadDly_reg <= tempBad;
    end
  end
  assign irq = |(irqStat_reg & irqMask_reg);

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  logic awHeld_reg; // write address taken
  logic wHeld_reg; // write data taken
  logic [ADDR_W-1:0] wAddr_reg; // held write address
  logic [31:0] wData_reg; // held write data
  logic wLane0_reg; // low byte lane strobe
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic wMapped; // held address decodes

  assign awready = ~awHeld_reg & ~bvalid_reg;
  assign wready = ~wHeld_reg & ~bvalid_reg;
  assign doWrite = awHeld_reg & wHeld_reg & ~bvalid_reg;
  assign wMapped = (wAddr_reg == OFS_CTRL) || (wAddr_reg == OFS_STATE) ||
                   (wAddr_reg == OFS_TIMER) || (wAddr_reg == OFS_IRQ_STAT) ||
                   (wAddr_reg == OFS_IRQ_MASK);
  assign irqClear = (doWrite && wLane0_reg && (wAddr_reg == OFS_IRQ_STAT)) ?
                    wData_reg[EV_N-1:0] : '0;

  // address and data taken in either order; answer follows both
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      wAddr_reg <= '0;
      wData_reg <= '0;
      wLane0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_reg <= 1'b1;
        wAddr_reg <= {awaddr[ADDR_W-1:2], 2'b00};
      end
      if (wvalid && wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= wdata;
        wLane0_reg <= wstrb[0];
      end
      if (doWrite) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;

  // writable registers; read-only ones ignore writes
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      ctrlEnable_reg <= CTRL_ENABLE_RST;
      irqMask_reg <= IRQ_MASK_RST;
    end else if (doWrite && wLane0_reg) begin
      if (wAddr_reg == OFS_CTRL) begin
        ctrlEnable_reg <= wData_reg[0];
      end
      if (wAddr_reg == OFS_IRQ_MASK) begin
        irqMask_reg <= wData_reg[EV_N-1:0];
      end
    end
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdMux; // decoded read value
  logic rdMapped; // read address decodes

  // read decode; unused bits read zero
  always_comb begin
    rdMux = 32'h0;
    rdMapped = 1'b1;
    unique case ({araddr[ADDR_W-1:2], 2'b00})
      OFS_CTRL: rdMux[0] = ctrlEnable_reg;
      OFS_STATE: rdMux = {20'h0, faultInd, statusEoc, trickleMode, chargeOn, state_reg};
      OFS_TIMER: rdMux[CNT_W-1:0] = timerCount;
      OFS_IRQ_STAT: rdMux[EV_N-1:0] = irqStat_reg;
      OFS_IRQ_MASK: rdMux[EV_N-1:0] = irqMask_reg;
      default: rdMapped = 1'b0; // unmapped: zero data, error reply
    endcase
  end

  assign arready = ~rvalid_reg;

  // read answered one cycle after the address is taken
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rdMux;
      rresp_reg <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

endmodule : ccsm_top
`default_nettype wire

// ==== sim/ccsm_props.sv ====
// Purpose: port-level checks of the charger state machine
// Assumes: pins cross two sync flops, then state, then outputs
// Notes: bound onto ccsm_top below the module
`timescale 1ns/1ns
`default_nettype none
module ccsm_props (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic supplyAbovePor,
  input wire logic chargeEnable,
  input wire logic timeoutEnableInput,
  input wire logic endOfCharge,
  input wire logic tempInWindow,
  input wire logic chargeOn,
  input wire logic trickleMode,
  input wire logic statusEoc,
  input wire logic faultInd
);
  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // six samples cover the pin-to-output pipeline
  chk_supply_off: assert property (!supplyAbovePor [*6] |-> !chargeOn && !faultInd)
    else $error("outputs active with supply low");
  chk_disabled_idle: assert property (!chargeEnable [*6] |-> !chargeOn)
    else $error("current on while disabled");
  chk_temp_pause: assert property (!tempInWindow [*6] |-> !chargeOn)
    else $error("current on with temperature out of window");
  chk_fault_off: assert property (faultInd [*2] |-> !chargeOn)
    else $error("current on during fault");
  chk_eoc_phase: assert property (statusEoc |-> !trickleMode)
    else $error("end of charge shown in trickle");
  chk_fault_hold: assert property ((faultInd && tempInWindow && chargeEnable && supplyAbovePor) [*6]
    ##1 (chargeEnable && supplyAbovePor) |-> faultInd)
    else $error("fault left without enable or supply change");
  chk_timeout_off: assert property ((!timeoutEnableInput && tempInWindow) [*6] |-> !$rose(faultInd))
    else $error("timeout fault with timeout disabled");
  chk_eoc_cause: assert property ($rose(statusEoc) |->
    $past(endOfCharge, 3) || $past(endOfCharge, 4) || $past(endOfCharge, 5))
    else $error("end of charge shown without its input");
  // main scenarios seen
  cover property ($rose(faultInd));
  cover property ($rose(statusEoc));
  cover property ($fell(chargeOn) && statusEoc);
endmodule : ccsm_props
bind ccsm_top ccsm_props i_props (.mclk(mclk), .rst_n(rst_n), .supplyAbovePor(supplyAbovePor),
  .chargeEnable(chargeEnable), .timeoutEnableInput(timeoutEnableInput),
  .endOfCharge(endOfCharge), .tempInWindow(tempInWindow), .chargeOn(chargeOn),
  .trickleMode(trickleMode), .statusEoc(statusEoc), .faultInd(faultInd));
`default_nettype wire

// ==== sim/ccsm_osc_model.sv ====
// Purpose: stand-in for the capacitor-timed oscillator
// Assumes: one period is 2*HALF mclk cycles
// Notes: slow enough that the sync flops never miss an edge
`timescale 1ns/1ns
`default_nettype none
module ccsm_osc_model #(
  parameter int unsigned HALF = 2
) (
  input wire logic mclk,
  input wire logic rstN,
  output logic oscClk
);
  int cnt; // cycles in this half period
  // free running, each rising edge is one timer period
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      cnt <= 0;
      oscClk <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      oscClk <= ~oscClk;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : ccsm_osc_model
`default_nettype wire

// ==== sim/test_charge_cycle_state_machine.sv ====
// Purpose: directed run through the charge cycle
// Assumes: timeout shortened to 64 periods of 4 mclk
// Notes: state polled over AXI4-Lite, windows allow poll lag
`timescale 1ns/1ns
`default_nettype none
module test_charge_cycle_state_machine;
  import ccsm_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  logic mclk = 1'b0, rst_n = 1'b0, supplyAbovePor = 1'b0, chargeEnable = 1'b0;
  logic timeoutEnableInput = 1'b1, battAbovePrecond = 1'b0, endOfCharge = 1'b0;
  logic tempInWindow = 1'b1, oscClk, chargeOn, trickleMode, statusEoc, faultInd, irq;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd, tmr;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, rs;
  int fail_count = 0, cmp_count = 0, n;
  always #5 mclk = ~mclk; // 100 MHz
  ccsm_osc_model #(.HALF(2)) i_osc (.mclk(mclk), .rstN(rst_n), .oscClk(oscClk));
  ccsm_top #(.TIMEOUT_TICKS(64)) i_dut (.mclk(mclk), .rst_n(rst_n),
    .supplyAbovePor(supplyAbovePor), .chargeEnable(chargeEnable),
    .timeoutEnableInput(timeoutEnableInput), .battAbovePrecond(battAbovePrecond),
    .endOfCharge(endOfCharge), .tempInWindow(tempInWindow), .oscClk(oscClk),
    .chargeOn(chargeOn), .trickleMode(trickleMode), .statusEoc(statusEoc),
    .faultInd(faultInd), .irq(irq), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic chk1(input string nm, input logic seen, input logic exp);
    chk(nm, {31'h0, seen}, {31'h0, exp});
  endtask : chk1
  task automatic hang();
    fail_count++;
    $display("[FAIL] wait expected done seen timeout");
    stop_test();
  endtask : hang
  // write: both channels offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while ((awvalid || wvalid) && k < 50) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      k++;
    end
    while (!bvalid && k < 50) begin @(posedge mclk); k++; end
    rs = bresp;
    bready <= 1'b0;
    if (k >= 50) hang();
  endtask : axw
  task automatic axr(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge mclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (arvalid && k < 50) begin @(posedge mclk); if (arready) arvalid <= 1'b0; k++; end
    while (!rvalid && k < 50) begin @(posedge mclk); k++; end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (k >= 50) hang();
  endtask : axr
  // poll the one-hot state until it matches or the bound runs out
  task automatic wait_st(input logic [7:0] e);
    int k;
    k = 0;
    axr(OFS_STATE);
    while (rd[7:0] !== e && k < 300) begin axr(OFS_STATE); k++; end
    chk("state", {24'h0, rd[7:0]}, {24'h0, e});
  endtask : wait_st
  task automatic fault_in(output int k);
    k = 0;
    while (faultInd !== 1'b1 && k < 1000) begin @(posedge mclk); k++; end
    if (k >= 1000) hang();
  endtask : fault_in
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    axr(OFS_CTRL); chk("ctrl", rd, {31'h0, CTRL_ENABLE_RST});
    axr(OFS_IRQ_MASK); chk("mask", rd, {28'h0, IRQ_MASK_RST});
    wait_st(CCSM_OFF);
    axr(8'h20); chk("rresp", {30'h0, rs}, {30'h0, RESP_SLVERR}); chk("rdata", rd, 32'h0);
    axw(8'h20, 32'h1); chk("bresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
    supplyAbovePor <= 1'b1;
    wait_st(CCSM_DISABLED); chk1("current", chargeOn, 1'b0);
    chargeEnable <= 1'b1;
    wait_st(CCSM_TRICKLE); chk1("trickle", trickleMode, 1'b1);
    axr(OFS_TIMER); chk1("timer clear", rd < 4, 1'b1);
    fault_in(n); chk1("trickle limit", n >= 20 && n <= 40, 1'b1);
    wait_st(CCSM_FAULT); chk1("fault", faultInd, 1'b1);
    axr(OFS_IRQ_STAT); chk1("fault event", rd[EV_FAULT], 1'b1);
    chk1("irq masked", irq, 1'b0);
    axw(OFS_IRQ_MASK, 32'h1); chk1("irq", irq, 1'b1);
    axw(OFS_IRQ_STAT, 32'h1); chk1("irq clear", irq, 1'b0);
    battAbovePrecond <= 1'b1; // no way out of fault but enable or supply
    repeat (20) @(posedge mclk);
    wait_st(CCSM_FAULT);
    chargeEnable <= 1'b0;
    wait_st(CCSM_DISABLED);
    chargeEnable <= 1'b1;
    wait_st(CCSM_FAST);
    axr(OFS_TIMER); chk1("timer clear", rd < 4, 1'b1);
    fault_in(n); chk1("fast limit", n >= 230 && n <= 270, 1'b1);
    chargeEnable <= 1'b0; endOfCharge <= 1'b1;
    wait_st(CCSM_DISABLED);
    chargeEnable <= 1'b1;
    wait_st(CCSM_COMPLETE); chk1("on", chargeOn, 1'b1); chk1("eoc", statusEoc, 1'b1);
    wait_st(CCSM_INHIBIT); chk1("on", chargeOn, 1'b0); chk1("eoc", statusEoc, 1'b1);
    chargeEnable <= 1'b0; endOfCharge <= 1'b0; battAbovePrecond <= 1'b0;
    timeoutEnableInput <= 1'b0;
    wait_st(CCSM_DISABLED);
    chargeEnable <= 1'b1;
    wait_st(CCSM_TRICKLE);
    tempInWindow <= 1'b0; // pause while the timer is still low
    repeat (10) @(posedge mclk);
    chk1("temp fault", faultInd, 1'b1);
    chk1("paused", chargeOn, 1'b0);
    axr(OFS_TIMER); tmr = rd;
    repeat (40) @(posedge mclk);
    axr(OFS_TIMER); chk("timer hold", rd, tmr);
    tempInWindow <= 1'b1;
    repeat (400) @(posedge mclk);
    wait_st(CCSM_TRICKLE);
    supplyAbovePor <= 1'b0;
    wait_st(CCSM_OFF);
    stop_test();
  end
endmodule : test_charge_cycle_state_machine
`default_nettype wire
